/* dsl_host_model.sv */
// Host model driving the three-wire serial programming pins
`timescale 1ns/100ps

module dsl_host_model (
  output logic ser_clk_out,
  output logic ser_data_out,
  output logic strobe_out
);
  localparam time HALF = 16ns;

  initial begin
    ser_clk_out  = 1'b0;
    ser_data_out = 1'b0;
    strobe_out   = 1'b0;
  end

  // ----------------------------------------
  // Pin sequences
  // ----------------------------------------
  // Bare clock pulses with no strobe
  task automatic run_clocks(input int n);
    repeat (n) begin
      #HALF ser_clk_out = 1'b1;
      #HALF ser_clk_out = 1'b0;
    end
  endtask

  // Bit 21 goes out first; clock may be left high
  task automatic shift_word(input logic [21:0] w, input logic keep_high);
    if (ser_clk_out) begin
      #HALF ser_clk_out = 1'b0;
    end
    for (int i = 21; i >= 0; i--) begin
      ser_data_out = w[i];
      #HALF ser_clk_out = 1'b1;
      #HALF;
      if (i > 0 || !keep_high) begin
        ser_clk_out = 1'b0;
      end
    end
    ser_data_out = ~w[0];
  endtask

  // Strobe kept long, clock still around it
  task automatic latch();
    #HALF strobe_out = 1'b1;
    #120ns strobe_out = 1'b0;
    #100ns;
  endtask
endmodule  // dsl_host_model

/* dsl_loader.sv */
// Serial configuration loader for a dual frequency synthesizer
`timescale 1ns/100ps

module dsl_loader (
  input  wire logic                                      sys_clk_in,
  input  wire logic                                      reset_n_in,
  input  wire logic                                      ce_in,
  input  wire logic                                      ser_clk_in,
  input  wire logic                                      ser_data_in,
  input  wire logic                                      word_latch_strobe_in,
  input  wire logic [1:0]                                lock_detect_in,
  input  wire logic [1:0]                                ref_div_pulse_in,
  input  wire logic [1:0]                                prog_div_pulse_in,
  output logic      [1:0][dsl_pkg::REF_W-1:0]            ref_divide_out,
  output logic      [1:0]                                phase_sense_out,
  output logic      [1:0]                                pump_current_sel_out,
  output logic      [1:0]                                pump_hiz_out,
  output logic      [1:0]                                lock_monitor_sel_out,
  output logic      [1:0]                                divider_monitor_sel_out,
  output logic      [1:0][dsl_pkg::SWALLOW_USED-1:0]     swallow_count_out,
  output logic      [1:0][dsl_pkg::MAIN_W-1:0]           main_count_out,
  output logic      [1:0]                                modulus_sel_out,
  output logic      [1:0]                                sleep_ctrl_out,
  output logic      [1:0]                                main_counter_en_out,
  output logic      [1:0]                                phase_comp_en_out,
  output logic      [1:0]                                pump_drive_en_out,
  output logic      [1:0]                                rf_input_en_out,
  output logic                                           ref_counter_en_out,
  output logic                                           ref_osc_input_en_out,
  output logic                                           monitor_pin_out,
  output logic      [1:0]                                counter_reset_out
);

  // ---------------------------------------------------------------------------
  // Field extraction
  // ---------------------------------------------------------------------------
  // Bit n of a field sits n places after its first bit in the word
  function automatic logic [dsl_pkg::REF_W-1:0] get_ref(
    input logic [dsl_pkg::WORD_W-1:0] word
  );
    logic [dsl_pkg::REF_W-1:0] val;
    val = '0;
    for (int n = 0; n < dsl_pkg::REF_W; n++) begin
      val[n] = word[dsl_pkg::POS_REF_1-n];
    end
    return val;
  endfunction

  function automatic logic [dsl_pkg::SWALLOW_USED-1:0] get_swallow(
    input logic [dsl_pkg::WORD_W-1:0] word
  );
    logic [dsl_pkg::SWALLOW_USED-1:0] val;
    val = '0;
    for (int n = 0; n < dsl_pkg::SWALLOW_USED; n++) begin
      val[n] = word[dsl_pkg::POS_SWALLOW1-n];
    end
    return val;
  endfunction

  function automatic logic [dsl_pkg::MAIN_W-1:0] get_main(
    input logic [dsl_pkg::WORD_W-1:0] word
  );
    logic [dsl_pkg::MAIN_W-1:0] val;
    val = '0;
    for (int n = 0; n < dsl_pkg::MAIN_W; n++) begin
      val[n] = word[dsl_pkg::POS_MAIN_1-n];
    end
    return val;
  endfunction

  // Monitor source from the per-loop select bits
  function automatic dsl_pkg::dsl_mon_e mon_mode(
    input logic [1:0] fo,
    input logic [1:0] ld
  );
    dsl_pkg::dsl_mon_e mode;
    mode = dsl_pkg::MON_OFF;
    if (fo == 2'h0) begin
      mode = (ld == 2'h0) ? dsl_pkg::MON_OFF : dsl_pkg::MON_LOCK;
    end else if (fo == 2'h1) begin
      mode = dsl_pkg::MON_DIV_FIRST;
    end else if (fo == 2'h2) begin
      mode = dsl_pkg::MON_DIV_SECOND;
    end else begin
      mode = dsl_pkg::MON_CNT_RESET;
    end
    return mode;
  endfunction

  // ---------------------------------------------------------------------------
  // Link domain: shift register on the data clock
  // ---------------------------------------------------------------------------
  logic                        link_rst_meta;
  logic                        link_rst_n;
  logic                        link_ce_meta;
  logic                        link_ce;
  logic [dsl_pkg::WORD_W-1:0]  shift_reg;

  always_ff @(posedge ser_clk_in) begin
    link_rst_meta <= reset_n_in;
    link_rst_n    <= link_rst_meta;
    link_ce_meta  <= ce_in;
    link_ce       <= link_ce_meta;
  end

  // Edge-clocked, so a clock parked high shifts nothing; no sleep gating
  always_ff @(posedge ser_clk_in) begin
    if (!link_rst_n) begin
      shift_reg <= '0;
    end else if (link_ce) begin
      shift_reg <= {shift_reg[dsl_pkg::WORD_W-2:0], ser_data_in};
    end
  end

  // ---------------------------------------------------------------------------
  // Strobe crossing and capture decode
  // ---------------------------------------------------------------------------
  logic strobe_meta;
  logic strobe_sync;
  logic strobe_prev;

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      strobe_meta <= 1'b0;
      strobe_sync <= 1'b0;
      strobe_prev <= 1'b0;
    end else if (ce_in) begin
      strobe_meta <= word_latch_strobe_in;
      strobe_sync <= strobe_meta;
      strobe_prev <= strobe_sync;
    end
  end

  // Shift register is quiet while the strobe is high, so it is read here as
  // a word held stable by the handshake with the host
  wire                               latch_take  = ce_in & strobe_sync & ~strobe_prev;
  wire                               cap_dest_hi = shift_reg[dsl_pkg::POS_DEST_HI];
  wire                               cap_dest_lo = shift_reg[dsl_pkg::POS_DEST_LO];
  wire [dsl_pkg::REF_W-1:0]          cap_ref     = get_ref(shift_reg);
  wire [dsl_pkg::SWALLOW_USED-1:0]   cap_swallow = get_swallow(shift_reg);
  wire [dsl_pkg::MAIN_W-1:0]         cap_main    = get_main(shift_reg);

  // ---------------------------------------------------------------------------
  // Per-loop latched settings and enables
  // ---------------------------------------------------------------------------
  wire both_asleep = &sleep_ctrl_out;

  for (genvar i = 0; i < dsl_pkg::NUM_LOOPS; i++) begin : g_loop
    wire take_ref = latch_take & ~cap_dest_hi &
                    (cap_dest_lo == dsl_pkg::LOOP_DEST_LO[i]);
    wire take_cnt = latch_take & cap_dest_hi &
                    (cap_dest_lo == dsl_pkg::LOOP_DEST_LO[i]);

    always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
        ref_divide_out[i]          <= dsl_pkg::RST_REF_DIVIDE;
        phase_sense_out[i]         <= dsl_pkg::RST_BIT;
        pump_current_sel_out[i]    <= dsl_pkg::RST_BIT;
        pump_hiz_out[i]            <= dsl_pkg::RST_BIT;
        lock_monitor_sel_out[i]    <= dsl_pkg::RST_BIT;
        divider_monitor_sel_out[i] <= dsl_pkg::RST_BIT;
      end else if (take_ref) begin
        ref_divide_out[i]          <= cap_ref;
        phase_sense_out[i]         <= shift_reg[dsl_pkg::POS_PHASE];
        pump_current_sel_out[i]    <= shift_reg[dsl_pkg::POS_PUMP_CUR];
        pump_hiz_out[i]            <= shift_reg[dsl_pkg::POS_PUMP_HIZ];
        lock_monitor_sel_out[i]    <= shift_reg[dsl_pkg::POS_LOCK_MON];
        divider_monitor_sel_out[i] <= shift_reg[dsl_pkg::POS_DIV_MON];
      end
    end

    // Latch works whatever the sleep bits say
    always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
        swallow_count_out[i] <= dsl_pkg::RST_SWALLOW;
        main_count_out[i]    <= dsl_pkg::RST_MAIN;
        modulus_sel_out[i]   <= dsl_pkg::RST_BIT;
        sleep_ctrl_out[i]    <= dsl_pkg::RST_SLEEP;
      end else if (take_cnt) begin
        swallow_count_out[i] <= cap_swallow;
        main_count_out[i]    <= cap_main;
        modulus_sel_out[i]   <= shift_reg[dsl_pkg::POS_MODULUS];
        sleep_ctrl_out[i]    <= shift_reg[dsl_pkg::POS_SLEEP];
      end
    end

    wire next_awake    = ~sleep_ctrl_out[i];
    wire next_pump_drv = ~sleep_ctrl_out[i] & ~pump_hiz_out[i];

    always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
        main_counter_en_out[i] <= 1'b0;
        phase_comp_en_out[i]   <= 1'b0;
        pump_drive_en_out[i]   <= 1'b0;
        rf_input_en_out[i]     <= 1'b0;
      end else if (ce_in) begin
        main_counter_en_out[i] <= next_awake;
        phase_comp_en_out[i]   <= next_awake;
        pump_drive_en_out[i]   <= next_pump_drv;
        rf_input_en_out[i]     <= next_awake;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      ref_counter_en_out   <= 1'b0;
      ref_osc_input_en_out <= 1'b0;
    end else if (ce_in) begin
      ref_counter_en_out   <= ~both_asleep;
      ref_osc_input_en_out <= ~both_asleep;
    end
  end

  // ---------------------------------------------------------------------------
  // Monitor pin
  // ---------------------------------------------------------------------------
  logic [5:0] mon_meta;
  logic [5:0] mon_sync;

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      mon_meta <= 6'h00;
      mon_sync <= 6'h00;
    end else if (ce_in) begin
      mon_meta <= {prog_div_pulse_in, ref_div_pulse_in, lock_detect_in};
      mon_sync <= mon_meta;
    end
  end

  wire [1:0]          lock_s   = mon_sync[1:0];
  wire [1:0]          refdiv_s = mon_sync[3:2];
  wire [1:0]          prgdiv_s = mon_sync[5:4];
  wire [1:0]          ld_sel   = lock_monitor_sel_out;
  dsl_pkg::dsl_mon_e  mode;
  logic               next_monitor;
  logic [1:0]         next_cnt_reset;

  assign mode = mon_mode(divider_monitor_sel_out, ld_sel);

  always_comb begin
    next_monitor   = 1'b0;
    next_cnt_reset = 2'h0;
    case (mode)
      dsl_pkg::MON_LOCK: begin
        next_monitor = &(lock_s | ~ld_sel);
      end
      dsl_pkg::MON_DIV_FIRST: begin
        next_monitor = ld_sel[dsl_pkg::LOOP_FIRST] ? prgdiv_s[dsl_pkg::LOOP_FIRST]
                                                   : refdiv_s[dsl_pkg::LOOP_FIRST];
      end
      dsl_pkg::MON_DIV_SECOND: begin
        next_monitor = ld_sel[dsl_pkg::LOOP_SECOND] ? prgdiv_s[dsl_pkg::LOOP_SECOND]
                                                    : refdiv_s[dsl_pkg::LOOP_SECOND];
      end
      dsl_pkg::MON_CNT_RESET: begin
        next_cnt_reset = ld_sel;
      end
      default: begin
        next_monitor = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      monitor_pin_out   <= 1'b0;
      counter_reset_out <= 2'h0;
    end else if (ce_in) begin
      monitor_pin_out   <= next_monitor;
      counter_reset_out <= next_cnt_reset;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  AST_SHIFT_ORDER: assert property (@(posedge ser_clk_in) disable iff (!link_rst_n)
    link_ce |=> shift_reg == {$past(shift_reg[dsl_pkg::WORD_W-2:0]), $past(ser_data_in)})
    else $error("shift register did not take data msb first");

  AST_HOLD: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !latch_take |=> $stable(ref_divide_out) && $stable(main_count_out)
                    && $stable(sleep_ctrl_out) && $stable(pump_hiz_out))
    else $error("settings changed without a latch strobe");

  AST_STROBE_EDGE: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in && $rose(strobe_sync) |-> latch_take)
    else $error("strobe rise did not cause a latch");

  AST_REF_SECOND: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    latch_take && !cap_dest_hi && !cap_dest_lo |=>
      ref_divide_out[dsl_pkg::LOOP_SECOND] == $past(cap_ref)
      && $stable(ref_divide_out[dsl_pkg::LOOP_FIRST]))
    else $error("reference word for second loop misrouted");

  AST_REF_FIRST: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    latch_take && !cap_dest_hi && cap_dest_lo |=>
      ref_divide_out[dsl_pkg::LOOP_FIRST] == $past(cap_ref)
      && phase_sense_out[dsl_pkg::LOOP_FIRST] == $past(shift_reg[dsl_pkg::POS_PHASE]))
    else $error("reference word for first loop misrouted");

  AST_CNT_SECOND: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    latch_take && cap_dest_hi && !cap_dest_lo |=>
      swallow_count_out[dsl_pkg::LOOP_SECOND] == $past(cap_swallow)
      && main_count_out[dsl_pkg::LOOP_SECOND] == $past(cap_main))
    else $error("counter word for second loop misrouted");

  AST_CNT_FIRST: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    latch_take && cap_dest_hi && cap_dest_lo |=>
      sleep_ctrl_out[dsl_pkg::LOOP_FIRST] == $past(shift_reg[dsl_pkg::POS_SLEEP])
      && $stable(main_count_out[dsl_pkg::LOOP_SECOND]))
    else $error("counter word for first loop misrouted");

  AST_SLEEP_PUMP: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in && (sleep_ctrl_out[0] || pump_hiz_out[0]) |=> !pump_drive_en_out[0])
    else $error("pump driven while asleep or three-stated");

  AST_REF_SHUT: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in |=> ref_counter_en_out == !$past(both_asleep))
    else $error("reference counter enable wrong");

  AST_MON_OFF: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in && mode == dsl_pkg::MON_OFF |=> !monitor_pin_out)
    else $error("monitor pin not low when disabled");

  AST_SHIFT_FREEZE: assert property (@(posedge ser_clk_in) disable iff (!link_rst_n)
    !link_ce |=> $stable(shift_reg))
    else $error("shift register moved while frozen");

  AST_CFG_SECOND: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    latch_take && !cap_dest_hi && !cap_dest_lo |=>
      pump_current_sel_out[dsl_pkg::LOOP_SECOND] == $past(shift_reg[dsl_pkg::POS_PUMP_CUR])
      && pump_hiz_out[dsl_pkg::LOOP_SECOND] == $past(shift_reg[dsl_pkg::POS_PUMP_HIZ]))
    else $error("pump settings for second loop misrouted");

  AST_CFG_FIRST: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    latch_take && !cap_dest_hi && cap_dest_lo |=>
      lock_monitor_sel_out[dsl_pkg::LOOP_FIRST] == $past(shift_reg[dsl_pkg::POS_LOCK_MON])
      && divider_monitor_sel_out[dsl_pkg::LOOP_FIRST] == $past(shift_reg[dsl_pkg::POS_DIV_MON]))
    else $error("monitor settings for first loop misrouted");

  AST_MOD_SECOND: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    latch_take && cap_dest_hi && !cap_dest_lo |=>
      modulus_sel_out[dsl_pkg::LOOP_SECOND] == $past(shift_reg[dsl_pkg::POS_MODULUS])
      && sleep_ctrl_out[dsl_pkg::LOOP_SECOND] == $past(shift_reg[dsl_pkg::POS_SLEEP]))
    else $error("modulus or sleep for second loop misrouted");

  AST_CNT_FIRST_VAL: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    latch_take && cap_dest_hi && cap_dest_lo |=>
      swallow_count_out[dsl_pkg::LOOP_FIRST] == $past(cap_swallow)
      && main_count_out[dsl_pkg::LOOP_FIRST] == $past(cap_main))
    else $error("counter values for first loop misrouted");

  AST_SLEEP_SECOND: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in && sleep_ctrl_out[dsl_pkg::LOOP_SECOND] |=>
      !main_counter_en_out[dsl_pkg::LOOP_SECOND] && !phase_comp_en_out[dsl_pkg::LOOP_SECOND]
      && !rf_input_en_out[dsl_pkg::LOOP_SECOND] && !pump_drive_en_out[dsl_pkg::LOOP_SECOND])
    else $error("second loop active while asleep");

  AST_OSC_SHUT: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in |=> ref_osc_input_en_out == !$past(both_asleep))
    else $error("oscillator input enable wrong");

  AST_MON_UNLOCKED: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in && mode == dsl_pkg::MON_LOCK && (ld_sel & ~lock_s) != 2'h0 |=> !monitor_pin_out)
    else $error("monitor pin high while a selected loop is unlocked");

  AST_CNT_RESET: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in && mode == dsl_pkg::MON_CNT_RESET |=> counter_reset_out == $past(ld_sel)
    && !monitor_pin_out)
    else $error("counter reset outputs wrong");

  COV_REF_WORD: cover property (@(posedge sys_clk_in) latch_take && !cap_dest_hi);
  COV_CNT_WORD: cover property (@(posedge sys_clk_in) latch_take && cap_dest_hi);
  COV_BOTH_ASLEEP: cover property (@(posedge sys_clk_in) !ref_counter_en_out ##1 latch_take);
  COV_LOCK_MON: cover property (@(posedge sys_clk_in) mode == dsl_pkg::MON_LOCK && monitor_pin_out);
  COV_CNT_RESET: cover property (@(posedge sys_clk_in) counter_reset_out != 2'h0);

endmodule // dsl_loader

/* dsl_loader_test.sv */
// Self-checking testbench of the serial configuration loader
`timescale 1ns/100ps

`define CHK(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
  end \
end

module dsl_loader_test;
  logic             sys_clk, reset_n, ce;
  logic [1:0]       lock_det, ref_div, prog_div;
  logic             ser_clk, ser_data, strobe;
  logic [1:0][14:0] ref_divide;
  logic [1:0][5:0]  swallow;
  logic [1:0][10:0] main_cnt;
  logic [1:0]       phase, cur, hiz, lockm, divm, mods, sleep, mce, pce, pde, rfe, cres;
  logic             ref_en, osc_en, mon_pin;
  int               n_errors = 0;
  int               checked = 0;

  dsl_host_model dsl_host_model_i (
    .ser_clk_out  (ser_clk),
    .ser_data_out (ser_data),
    .strobe_out   (strobe)
  );

  dsl_loader dsl_loader_i (
    .sys_clk_in              (sys_clk),
    .reset_n_in              (reset_n),
    .ce_in                   (ce),
    .ser_clk_in              (ser_clk),
    .ser_data_in             (ser_data),
    .word_latch_strobe_in    (strobe),
    .lock_detect_in          (lock_det),
    .ref_div_pulse_in        (ref_div),
    .prog_div_pulse_in       (prog_div),
    .ref_divide_out          (ref_divide),
    .phase_sense_out         (phase),
    .pump_current_sel_out    (cur),
    .pump_hiz_out            (hiz),
    .lock_monitor_sel_out    (lockm),
    .divider_monitor_sel_out (divm),
    .swallow_count_out       (swallow),
    .main_count_out          (main_cnt),
    .modulus_sel_out         (mods),
    .sleep_ctrl_out          (sleep),
    .main_counter_en_out     (mce),
    .phase_comp_en_out       (pce),
    .pump_drive_en_out       (pde),
    .rf_input_en_out         (rfe),
    .ref_counter_en_out      (ref_en),
    .ref_osc_input_en_out    (osc_en),
    .monitor_pin_out         (mon_pin),
    .counter_reset_out       (cres)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Word builders and tasks
  // ----------------------------------------
  function automatic logic [21:0] ref_word(logic lo, logic [14:0] r, logic [4:0] t);
    logic [21:0] w;
    w = {1'b0, lo, 15'h0000, t};
    for (int n = 0; n < 15; n++) w[19-n] = r[n];
    return w;
  endfunction

  function automatic logic [21:0] cnt_word(logic lo, logic [6:0] a, logic [10:0] b,
                                           logic [1:0] t);
    logic [21:0] w;
    w = {1'b1, lo, 18'h00000, t};
    for (int n = 0; n < 7; n++) w[19-n] = a[n];
    for (int n = 0; n < 11; n++) w[12-n] = b[n];
    return w;
  endfunction

  task automatic wait_falls(int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic send(logic [21:0] w);
    dsl_host_model_i.shift_word(w, 1'b0);
    dsl_host_model_i.latch();
    wait_falls(3);
  endtask

  task automatic chk_ref(int i, logic [14:0] r, logic [4:0] t);
    `CHK(ref_divide[i], r)
    `CHK(phase[i], t[4])
    `CHK(cur[i], t[3])
    `CHK(hiz[i], t[2])
    `CHK(lockm[i], t[1])
    `CHK(divm[i], t[0])
  endtask

  task automatic chk_cnt(int i, logic [5:0] a, logic [10:0] b, logic [1:0] t);
    `CHK(swallow[i], a)
    `CHK(main_cnt[i], b)
    `CHK(mods[i], t[1])
    `CHK(sleep[i], t[0])
  endtask

  task automatic mon(logic [1:0] lk, logic [1:0] rd, logic exp);
    lock_det = lk;
    ref_div = rd;
    wait_falls(6);
    `CHK(mon_pin, exp)
  endtask

  task automatic final_report();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    n_errors++;
    final_report();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    lock_det = 2'h0;
    ref_div = 2'h0;
    prog_div = 2'h0;
    fork
      dsl_host_model_i.run_clocks(4);
    join_none
    wait_falls(10);
    reset_n = 1'b1;
    // Link reset copy releases only on data clock edges
    dsl_host_model_i.run_clocks(3);
    wait_falls(3);
    `CHK(ref_divide, {15'h0003, 15'h0003})
    `CHK(main_cnt, {11'h003, 11'h003})
    `CHK(sleep, 2'h3)
    `CHK(ref_en, 1'h0)
    send(ref_word(1'b0, 15'h7FFF, 5'h15));
    chk_ref(1, 15'h7FFF, 5'h15);
    send(ref_word(1'b1, 15'h4D2B, 5'h0A));
    chk_ref(0, 15'h4D2B, 5'h0A);
    chk_ref(1, 15'h7FFF, 5'h15);
    send(cnt_word(1'b0, 7'h7F, 11'h7FF, 2'h3));
    chk_cnt(1, 6'h3F, 11'h7FF, 2'h3);
    send(cnt_word(1'b1, 7'h40, 11'h5A5, 2'h0));
    chk_cnt(0, 6'h00, 11'h5A5, 2'h0);
    chk_cnt(1, 6'h3F, 11'h7FF, 2'h3);
    `CHK(mce, 2'h1)
    `CHK(pce, 2'h1)
    `CHK(rfe, 2'h1)
    `CHK(pde, 2'h1)
    `CHK(ref_en, 1'h1)
    `CHK(osc_en, 1'h1)
    dsl_host_model_i.shift_word(ref_word(1'b1, 15'h1234, 5'h1E), 1'b1);
    wait_falls(4);
    chk_ref(0, 15'h4D2B, 5'h0A);
    dsl_host_model_i.latch();
    wait_falls(3);
    chk_ref(0, 15'h1234, 5'h1E);
    `CHK(pde, 2'h0)
    mon(2'h0, 2'h2, 1'h1);
    mon(2'h3, 2'h0, 1'h0);
    send(ref_word(1'b0, 15'h0005, 5'h00));
    chk_ref(1, 15'h0005, 5'h00);
    mon(2'h1, 2'h0, 1'h1);
    mon(2'h2, 2'h3, 1'h0);
    send(ref_word(1'b1, 15'h0003, 5'h03));
    prog_div = 2'h1;
    mon(2'h0, 2'h0, 1'h1);
    send(ref_word(1'b0, 15'h0005, 5'h03));
    `CHK(cres, 2'h3)
    `CHK(mon_pin, 1'h0)
    send(cnt_word(1'b1, 7'h01, 11'h003, 2'h1));
    `CHK(ref_en, 1'h0)
    `CHK(osc_en, 1'h0)
    `CHK(mce, 2'h0)
    ce = 1'b0;
    send(ref_word(1'b1, 15'h0777, 5'h1F));
    chk_ref(0, 15'h0003, 5'h03);
    ce = 1'b1;
    final_report();
  end
endmodule  // dsl_loader_test

/* dsl_pkg.sv */
// Constants, field layout and reset values of the serial configuration loader

package dsl_pkg;

  // ---------------------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------------------
  localparam int WORD_W       = 22;
  localparam int REF_W        = 15;
  localparam int SWALLOW_W    = 7;
  localparam int SWALLOW_USED = 6;
  localparam int MAIN_W       = 11;
  localparam int NUM_LOOPS    = 2;
  localparam int POS_DEST_HI  = 21;
  localparam int POS_DEST_LO  = 20;
  localparam int POS_REF_1    = 19;
  localparam int POS_PHASE    = 4;
  localparam int POS_PUMP_CUR = 3;
  localparam int POS_PUMP_HIZ = 2;
  localparam int POS_LOCK_MON = 1;
  localparam int POS_DIV_MON  = 0;
  localparam int POS_SWALLOW1 = 19;
  localparam int POS_MAIN_1   = 12;
  localparam int POS_MODULUS  = 1;
  localparam int POS_SLEEP    = 0;

  // ---------------------------------------------------------------------------
  // Loop indices and destination low bit per loop
  // ---------------------------------------------------------------------------
  localparam int         LOOP_FIRST   = 0;
  localparam int         LOOP_SECOND  = 1;
  localparam logic [1:0] LOOP_DEST_LO = 2'h1;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [REF_W-1:0]        RST_REF_DIVIDE = 15'h0003;
  localparam logic [SWALLOW_USED-1:0] RST_SWALLOW    = 6'h00;
  localparam logic [MAIN_W-1:0]       RST_MAIN       = 11'h003;
  localparam logic                    RST_SLEEP      = 1'h1;
  localparam logic                    RST_BIT        = 1'h0;

  // ---------------------------------------------------------------------------
  // Monitor pin modes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MON_OFF,
    MON_LOCK,
    MON_DIV_FIRST,
    MON_DIV_SECOND,
    MON_CNT_RESET
  } dsl_mon_e;

endpackage
